/* File: pkg/sync_serial_defines.svh */
// timing counts, field positions and reset values of the serial framing engine
`ifndef SYNC_SERIAL_DEFINES_SVH
`define SYNC_SERIAL_DEFINES_SVH

`define SSF_WORD_W        16
`define SSF_MIN_SIZE_M1   4'h3
`define SSF_CTRL_BITS     6'h08
`define SSF_CTRL_SKIP     6'h09
`define SSF_TAIL_HALVES   2'h2
`define SSF_TX_MSB        4'hF
`define SSF_RST_WORD      16'h0000
`define SSF_RST_DIV       16'h0000

`endif

/* File: pkg/sync_serial_pkg.sv */
// types shared by the serial framing engine
package sync_serial_pkg;

  // static configuration, changed only while the port is disabled
  typedef struct packed {
    logic        enable;
    logic        master;
    logic        ctrl_word;
    logic        clock_polarity_sel;
    logic        clock_phase_sel;
    logic [3:0]  size_m1;
    logic [15:0] half_div_m1;
  } cfg_t;

  // received word and its strobe
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } rx_word_t;

  typedef enum logic [2:0] {
    M_IDLE,
    M_ACTIVE,
    M_TAIL,
    M_GAP
  } master_state_t;

endpackage

/* File: logic/sync_serial_frame_engine.sv */
// serial framing engine: spi variants and control-word format as master, spi variants only as slave
//
// Behaviour
// RULE1 - frames of 4 to 16 bits, most significant bit first
// RULE2 - idle serial_clock low with polarity 0, high with polarity 1
// RULE3 - phase 0 captures on first clock edge, phase 1 on second
// RULE4 - idle spi: frame_select high, serial_tx driven low
// RULE5 - clock pad driven as master, undriven as slave
// RULE6 - master starts by lowering frame_select and enabling serial_tx
// RULE7 - phase 0: data half period after select, first edge half later
// RULE8 - polarity 0 phase 0: sample rising, change falling
// RULE9 - polarity 0 phase 1: data and rising edge together, sample falling
// RULE10 - polarity 1 phase 0: first edge falling, sample falling
// RULE11 - polarity 1 phase 1: falling edge with data, sample rising
// RULE12 - select returns high one clock period after last capture
// RULE13 - phase 0 bursts pulse select high between words
// RULE14 - phase 1 bursts keep select low between words
// RULE15 - control-word frame starts with 8-bit word, input ignored meanwhile
// RULE16 - slave decodes for one wait clock then returns 4 to 16 bits
// RULE17 - idle control-word format: clock low, select high, tx low
// RULE18 - control word loaded and msb driven as select falls
// RULE19 - control bits on rising edges, response latched on rising edges
// RULE20 - single control frame: select high one period after last latch
// RULE21 - continuous control frames: next control byte follows on falling edge
// RULE22 - slave may release serial_rx after last bit or select high
// RULE23 - master gives select setup of two periods before first sample; code gives one period, half a period in control-word format
// RULE24 - each complete spi word pushed to receive side after last capture
`timescale 1ns/1ps
`include "sync_serial_defines.svh"

module sync_serial_frame_engine
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire sync_serial_pkg::cfg_t   cfg,
  input  wire logic                    tx_valid,
  input  wire logic [15:0]             tx_data,
  output logic                         tx_ready,
  output sync_serial_pkg::rx_word_t    rx_word,
  output logic                         busy,
  input  wire logic                    serial_clock_i,
  output logic                         serial_clock_o,
  output logic                         serial_clock_oe,
  input  wire logic                    frame_select_i,
  output logic                         frame_select_o,
  output logic                         frame_select_oe,
  output logic                         serial_tx_o,
  output logic                         serial_tx_oe,
  input  wire logic                    serial_rx_i
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  sync_serial_pkg::master_state_t state;
  logic [15:0] div_cnt;
  logic [5:0]  step;
  logic [1:0]  tail_cnt;
  logic [15:0] hold;
  logic        hold_full;
  logic [15:0] tx_shift;
  logic [15:0] rx_shift;
  logic        m_tx;
  logic        m_on;
  logic        s_on;
  logic        link_clear;
  logic        rx_meta;
  logic        rx_sync;
  logic        fs_meta;
  logic        fs_sync;
  logic        done_meta;
  logic        done_sync;
  logic        done_prev;
  logic [15:0] s_word;
  logic        s_word_full;
  // link domain
  logic [3:0]  s_cnt;
  logic [3:0]  s_idx;
  logic [15:0] s_rx_sh;
  logic [15:0] s_rx_word;
  logic        s_done_tgl;

  // ****************************************************************
  // configuration decode
  // ****************************************************************
  // sizes below four bits are raised to four
  wire [3:0]  size_m1   = (cfg.size_m1 < `SSF_MIN_SIZE_M1) ? `SSF_MIN_SIZE_M1 : cfg.size_m1; // RULE1
  wire        ctrl      = cfg.ctrl_word;
  wire        phase     = ctrl ? 1'b0 : cfg.clock_phase_sel;
  wire        idle_clk  = ctrl ? 1'b0 : cfg.clock_polarity_sel; // RULE2 RULE17
  wire        lead      = !ctrl && !phase; // RULE7
  wire        sample_even = !phase; // RULE3
  wire [3:0]  shift_amt = 4'hF - size_m1;
  wire [15:0] rx_mask   = 16'hFFFF >> shift_amt;
  wire [5:0]  total     = ctrl ? (`SSF_CTRL_SKIP + {2'h0, size_m1} + 6'h01) : ({2'h0, size_m1} + 6'h01);

  // ****************************************************************
  // half-period timing and edge bookkeeping
  // ****************************************************************
  wire        running   = (state != sync_serial_pkg::M_IDLE);
  wire        half_tick = running && (div_cnt == 16'h0000);
  wire [5:0]  edge_k    = step - {5'h00, lead};
  wire        present0  = lead && (step == 6'h00);
  wire        is_sample = (edge_k[0] == !sample_even); // RULE8 RULE9 RULE10 RULE11
  wire [5:0]  sample_no = {1'b0, edge_k[5:1]};
  wire        last_smp  = is_sample && (sample_no == total - 6'h01);
  wire        keep_rx   = !(ctrl && (sample_no < `SSF_CTRL_SKIP)); // RULE15
  wire [15:0] rx_next   = keep_rx ? {rx_shift[14:0], rx_sync} : rx_shift;
  wire [15:0] load_word = ctrl ? {hold[7:0], 8'h00} : (hold << shift_amt); // RULE1
  wire        start_ok  = m_on && hold_full;
  wire        take_tx   = tx_valid && tx_ready;
  wire        s_done    = done_sync ^ done_prev;

  // ****************************************************************
  // transmit word holding stage
  // ****************************************************************
  // one word waits here; the engine or the slave path drains it
  wire m_take  = m_on && half_tick && (
                   ((state == sync_serial_pkg::M_GAP)) ||
                   ((state == sync_serial_pkg::M_ACTIVE) && !present0 && last_smp && !ctrl && phase && hold_full) ||
                   ((state == sync_serial_pkg::M_TAIL) && (tail_cnt == `SSF_TAIL_HALVES) && ctrl && hold_full));
  wire m_start = (state == sync_serial_pkg::M_IDLE) && start_ok;
  wire s_take  = s_on && hold_full && (s_done || (!s_word_full && fs_sync));
  wire drained = m_take || m_start || s_take;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hold_full <= 1'b0;
      hold      <= `SSF_RST_WORD;
      tx_ready  <= 1'b0;
    end
    else
    begin
      if (take_tx)
      begin
        hold      <= tx_data;
        hold_full <= 1'b1;
      end
      else if (drained)
      begin
        hold_full <= 1'b0;
      end
      tx_ready <= !(hold_full && !drained) && !take_tx;
    end
  end

  // ****************************************************************
  // pin and handshake synchronisers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_meta   <= 1'b0;
      rx_sync   <= 1'b0;
      fs_meta   <= 1'b1;
      fs_sync   <= 1'b1;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end
    else
    begin
      rx_meta   <= serial_rx_i;
      rx_sync   <= rx_meta;
      fs_meta   <= frame_select_i;
      fs_sync   <= fs_meta;
      done_meta <= s_done_tgl;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  // ****************************************************************
  // role and pad enables
  // ****************************************************************
  // pad enables follow the role, so a slave never fights the clock line
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      m_on            <= 1'b0;
      s_on            <= 1'b0;
      link_clear      <= 1'b1;
      serial_clock_oe <= 1'b0;
      frame_select_oe <= 1'b0;
      serial_tx_oe    <= 1'b0;
    end
    else
    begin
      m_on            <= cfg.enable && cfg.master;
      s_on            <= cfg.enable && !cfg.master;
      link_clear      <= !(cfg.enable && !cfg.master);
      serial_clock_oe <= cfg.enable && cfg.master; // RULE5
      frame_select_oe <= cfg.enable && cfg.master;
      serial_tx_oe    <= cfg.enable && (cfg.master || !fs_sync); // RULE4 RULE6
    end
  end

  // ****************************************************************
  // master frame sequencer
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state          <= sync_serial_pkg::M_IDLE;
      div_cnt        <= `SSF_RST_DIV;
      step           <= 6'h00;
      tail_cnt       <= 2'h0;
      tx_shift       <= `SSF_RST_WORD;
      rx_shift       <= `SSF_RST_WORD;
      m_tx           <= 1'b0;
      serial_clock_o <= 1'b0;
      frame_select_o <= 1'b1;
      rx_word        <= '0;
      busy           <= 1'b0;
    end
    else
    begin
      rx_word.valid <= 1'b0;
      busy          <= running;
      div_cnt       <= half_tick || !running ? cfg.half_div_m1 : div_cnt - 16'h0001;
      case (state)
        sync_serial_pkg::M_IDLE:
        begin
          serial_clock_o <= idle_clk; // RULE2 RULE17
          frame_select_o <= 1'b1;
          m_tx           <= 1'b0; // RULE4
          if (m_start)
          begin
            // select falls and the word is loaded at the same edge
            frame_select_o <= 1'b0; // RULE6
            tx_shift       <= load_word;
            m_tx           <= ctrl ? hold[7] : 1'b0; // RULE18
            step           <= 6'h00;
            state          <= sync_serial_pkg::M_ACTIVE;
          end
        end
        sync_serial_pkg::M_ACTIVE:
        begin
          if (half_tick)
          begin
            step <= step + 6'h01;
            if (present0)
            begin
              m_tx <= tx_shift[`SSF_TX_MSB]; // RULE7
            end
            else
            begin
              serial_clock_o <= !serial_clock_o;
              if (!is_sample)
              begin
                if (!sample_even && (edge_k == 6'h00))
                begin
                  m_tx <= tx_shift[`SSF_TX_MSB]; // RULE9 RULE11
                end
                else
                begin
                  tx_shift <= tx_shift << 1;
                  m_tx     <= tx_shift[14];
                end
              end
              else
              begin
                rx_shift <= rx_next; // RULE19
                if (last_smp)
                begin
                  if (!ctrl)
                  begin
                    rx_word.valid <= 1'b1; // RULE24
                    rx_word.data  <= rx_next & rx_mask;
                  end
                  if (!ctrl && phase && hold_full)
                  begin
                    // select stays low; the next change edge carries the new msb
                    tx_shift <= load_word; // RULE14
                    step     <= 6'h00;
                  end
                  else
                  begin
                    tail_cnt <= `SSF_TAIL_HALVES;
                    state    <= sync_serial_pkg::M_TAIL;
                  end
                end
              end
            end
          end
        end
        sync_serial_pkg::M_TAIL:
        begin
          if (half_tick)
          begin
            tail_cnt       <= tail_cnt - 2'h1;
            serial_clock_o <= idle_clk;
            if (tail_cnt == `SSF_TAIL_HALVES)
            begin
              if (ctrl && hold_full)
              begin
                // falling edge: response out, next control byte on the line
                rx_word.valid <= 1'b1; // RULE21
                rx_word.data  <= rx_shift & rx_mask;
                tx_shift      <= load_word;
                m_tx          <= hold[7];
                step          <= 6'h00;
                state         <= sync_serial_pkg::M_ACTIVE;
              end
            end
            else
            begin
              // one full period after the last capture
              frame_select_o <= 1'b1; // RULE12 RULE20
              m_tx           <= 1'b0;
              if (ctrl)
              begin
                rx_word.valid <= 1'b1; // RULE20
                rx_word.data  <= rx_shift & rx_mask;
              end
              state <= (!ctrl && !phase && hold_full && m_on) ? sync_serial_pkg::M_GAP
                                                              : sync_serial_pkg::M_IDLE; // RULE13
            end
          end
        end
        sync_serial_pkg::M_GAP:
        begin
          // select held high for half a period between phase-0 words
          if (half_tick)
          begin
            frame_select_o <= 1'b0; // RULE13
            tx_shift       <= load_word;
            m_tx           <= 1'b0;
            step           <= 6'h00;
            state          <= sync_serial_pkg::M_ACTIVE;
          end
        end
        default:
        begin
          state <= sync_serial_pkg::M_IDLE;
        end
      endcase
      // slave words completed in the link domain
      if (s_on && s_done)
      begin
        rx_word.valid <= 1'b1; // RULE24
        rx_word.data  <= s_rx_word & rx_mask;
      end
    end
  end

  // ****************************************************************
  // slave transmit word, handed to the link domain
  // ****************************************************************
  // reloaded only between words, so the link side sees it steady
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_word      <= `SSF_RST_WORD;
      s_word_full <= 1'b0;
    end
    else if (s_take)
    begin
      s_word      <= hold << shift_amt;
      s_word_full <= 1'b1;
    end
    else if (s_done || !s_on)
    begin
      s_word      <= `SSF_RST_WORD;
      s_word_full <= 1'b0;
    end
  end

  // ****************************************************************
  // slave link domain
  // ****************************************************************
  // folding polarity and phase into the clock puts every capture on a rising edge
  wire link_clk = serial_clock_i ^ (cfg.clock_polarity_sel ^ cfg.clock_phase_sel); // RULE3

  // capture side; select high restarts the word count
  always_ff @(posedge link_clk or posedge link_clear)
  begin
    if (link_clear)
    begin
      s_cnt      <= 4'h0;
      s_rx_sh    <= `SSF_RST_WORD;
      s_rx_word  <= `SSF_RST_WORD;
      s_done_tgl <= 1'b0;
    end
    else if (frame_select_i)
    begin
      s_cnt <= 4'h0;
    end
    else
    begin
      s_rx_sh <= {s_rx_sh[14:0], serial_rx_i}; // RULE8 RULE10
      if (s_cnt == size_m1)
      begin
        s_cnt      <= 4'h0;
        s_rx_word  <= {s_rx_sh[14:0], serial_rx_i};
        s_done_tgl <= !s_done_tgl;
      end
      else
      begin
        s_cnt <= s_cnt + 4'h1;
      end
    end
  end

  // launch side moves on the opposite edge
  always_ff @(negedge link_clk or posedge link_clear)
  begin
    if (link_clear)
    begin
      s_idx <= 4'h0;
    end
    else
    begin
      s_idx <= s_cnt; // RULE9 RULE11
    end
  end

  // ****************************************************************
  // shared transmit pin
  // ****************************************************************
  // the slave bit is picked from a steady word; the master bit is a flop
  wire s_tx = s_word[4'hF - s_idx];
  assign serial_tx_o = cfg.master ? m_tx : s_tx;

endmodule

/* File: tb/sync_serial_checker.sv */
// port-level checks of the serial framing engine
`timescale 1ns/1ps
module sync_serial_checker
(
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire sync_serial_pkg::cfg_t     cfg,
  input wire logic                      tx_valid,
  input wire logic                      tx_ready,
  input wire sync_serial_pkg::rx_word_t rx_word,
  input wire logic                      busy,
  input wire logic                      serial_clock_o,
  input wire logic                      serial_clock_oe,
  input wire logic                      frame_select_o,
  input wire logic                      frame_select_oe,
  input wire logic                      serial_tx_o,
  input wire logic                      serial_tx_oe
);
  // ******************************
  // timing helpers
  // ******************************
  logic [17:0] sel_cnt;
  logic [17:0] clk_age;
  logic        edge_seen;
  logic        clk_q;
  wire  [17:0] half      = 18'(cfg.half_div_m1) + 18'h0_0001;
  wire         clk_moved = serial_clock_o != clk_q;
  wire         ph1       = cfg.clock_phase_sel && !cfg.ctrl_word;
  wire         run       = cfg.enable && cfg.master;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // cycles since select fell and since the serial clock last moved
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sel_cnt   <= '0;
      clk_age   <= '0;
      edge_seen <= 1'b0;
      clk_q     <= 1'b0;
    end
    else
    begin
      clk_q     <= serial_clock_o;
      clk_age   <= clk_moved ? 18'h0_0001 : clk_age + 18'h0_0001;
      sel_cnt   <= frame_select_o ? '0 : sel_cnt + 18'h0_0001;
      edge_seen <= !frame_select_o && (edge_seen || clk_moved);
    end
  end

  sequence sel_rise;
    $rose(frame_select_o) && run;
  endsequence
  sequence sel_fall;
    $fell(frame_select_o);
  endsequence

  // edge timing: phase 0 waits a full period, phase 1 and control word half
  first_edge_a: assert property (!frame_select_o && !edge_seen && clk_moved && run
    |-> sel_cnt == ((ph1 || cfg.ctrl_word) ? half : 2 * half)) else $error("first clock edge mistimed");
  end_select_a: assert property (sel_rise |-> clk_age == (ph1 ? 2 * half : half))
    else $error("select rise mistimed");
  idle_clock_a: assert property (frame_select_o && $past(frame_select_o) && run && $past(cfg.enable)
    |-> serial_clock_o == (cfg.clock_polarity_sel && !cfg.ctrl_word)) else $error("idle clock level wrong");
  idle_tx_a: assert property (frame_select_o && !busy && !$past(busy) && run |-> !serial_tx_o)
    else $error("idle tx not low");
  frame_start_a: assert property (sel_fall |-> serial_tx_oe && run) else $error("tx off at start");
  master_pads_a: assert property (run |=> serial_clock_oe && frame_select_oe)
    else $error("master pads undriven");
  slave_pads_a: assert property (!cfg.master |=> !serial_clock_oe && !frame_select_oe)
    else $error("slave drives clock pad");
  take_word_a: assert property (tx_valid && tx_ready |=> !tx_ready) else $error("ready held after take");
  rx_word_a: assert property (rx_word.valid
    |-> (rx_word.data >> (cfg.size_m1 + 5'h01)) == 16'h0000 ##1 !rx_word.valid) else $error("bad rx word");
endmodule

bind sync_serial_frame_engine sync_serial_checker i_chk (.clk, .rst_n, .cfg, .tx_valid, .tx_ready, .rx_word,
  .busy, .serial_clock_o, .serial_clock_oe, .frame_select_o, .frame_select_oe, .serial_tx_o, .serial_tx_oe);

/* File: tb/spi_slave_model.sv */
// behavioural far-side peripheral for master-mode frames
`timescale 1ns/1ps
module spi_slave_model
(
  input  wire logic        sclk,
  input  wire logic        fs,
  input  wire logic        mosi,
  input  wire logic        cpha,
  input  wire logic        ctrl,
  input  wire logic [15:0] rsp,
  input  wire logic [4:0]  nbits,
  output logic             miso,
  output logic [15:0]      cap
);
  // ******************************
  // shifter and edge counter
  // ******************************
  logic [31:0] sh;
  int          e;
  initial miso = 1'b0;
  // reply reloaded at every word or control frame boundary of a burst
  always @(negedge fs)
  begin
    sh  = {2{rsp << (16 - nbits)}};
    e   = 0;
    cap = '0;
    if (!cpha && !ctrl) miso = sh[31];
  end
  // released line shows the inverse, never a stale bit
  always @(posedge fs) miso = ~miso;
  // capture on the phase-selected edge, change on the other
  always @(sclk)
  begin
    if (!fs)
    begin
      e++;
      if (ctrl)
      begin
        // the falling edge after the last reply bit opens the next frame
        if (e == 2 * nbits + 18)
        begin
          e  = 0;
          sh = {2{rsp << (16 - nbits)}};
        end
        if (sclk && e < 16) cap = {cap[14:0], mosi};
        if (!sclk && e >= 18)
        begin
          miso = sh[31];
          sh   = sh << 1;
        end
        else if (e < 18) miso = ~miso; // line is junk until the wait clock passes
      end
      else if (e[0] ^ cpha)
      begin
        cap = {cap[14:0], mosi};
        // phase 1 keeps select low, so the word count restarts here
        if (cpha && e == 2 * nbits)
        begin
          e  = 0;
          sh = {2{rsp << (16 - nbits)}};
        end
      end
      else if (!cpha)
      begin
        sh   = sh << 1;
        miso = sh[31];
      end
      else
      begin
        miso = sh[31];
        sh   = sh << 1;
      end
    end
  end
endmodule

/* File: tb/tb.sv */
// testbench: four spi variants, bursts, control word, slave frame
`timescale 1ns/1ps
module tb;
  // ******************************
  // signals, instances, tasks
  // ******************************
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  sync_serial_pkg::cfg_t     cfg = '0;
  logic                      tx_valid = 1'b0;
  logic [15:0]               tx_data = '0;
  logic                      tx_ready, busy, sck_o, sck_oe, fs_o, fs_oe, mosi, mosi_oe, miso;
  sync_serial_pkg::rx_word_t rx_word;
  logic                      sck_s = 1'b0, fs_s = 1'b1, rx_s = 1'b0;
  logic [15:0]               rsp = '0, cap, w, d, msk, got, last_rx;
  logic [3:0]                sz;
  int                        mismatches = 0, samples_checked = 0, rises = 0, rx_cnt = 0, rx_seen = 0;
  wire                       rx_line = cfg.master ? miso : rx_s;
  wire  [4:0]                nb = cfg.size_m1 + 5'h01;

  initial forever #2.5 clk = ~clk;
  sync_serial_frame_engine i_dut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_word(rx_word), .busy(busy), .serial_clock_i(sck_s), .serial_clock_o(sck_o),
    .serial_clock_oe(sck_oe), .frame_select_i(fs_s), .frame_select_o(fs_o), .frame_select_oe(fs_oe),
    .serial_tx_o(mosi), .serial_tx_oe(mosi_oe), .serial_rx_i(rx_line));
  spi_slave_model i_peer (.sclk(sck_o), .fs(fs_o), .mosi(mosi), .cpha(cfg.clock_phase_sel),
    .ctrl(cfg.ctrl_word), .rsp(rsp), .nbits(nb), .miso(miso), .cap(cap));

  // pulses are latched here so no wait can miss one
  always @(posedge clk)
    if (rx_word.valid === 1'b1)
    begin
      last_rx <= rx_word.data;
      rx_cnt  <= rx_cnt + 1;
    end
  always @(posedge fs_o) rises++;

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // 0: ready, 1: new rx word, 2: master idle
  task automatic wait_for(input int which);
    int n;
    n = 0;
    while (which == 0 ? tx_ready !== 1'b1 : which == 1 ? rx_cnt == rx_seen : (busy !== 1'b0 || fs_o !== 1'b1))
    begin
      @(negedge clk);
      n++;
      if (n > 3000)
      begin
        mismatches++;
        finish_test();
      end
    end
  endtask
  task automatic send(input logic [15:0] v);
    wait_for(0);
    tx_valid = 1'b1;
    tx_data  = v;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  task automatic get_rx(output logic [15:0] v);
    wait_for(1);
    v = last_rx;
    rx_seen++;
  endtask
  // configuration changes only while disabled
  task automatic setup(input logic m, input logic c, input logic p, input logic h, input logic [3:0] s);
    cfg.enable = 1'b0;
    repeat (4) @(negedge clk);
    cfg = '{1'b0, m, c, p, h, s, 16'h0003};
    repeat (4) @(negedge clk);
    cfg.enable = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    // every polarity and phase, sizes 4 8 12 16
    for (int i = 0; i < 4; i++)
    begin
      sz = 4'(4 * i + 3);
      setup(1'b1, 1'b0, i[1], i[0], sz);
      rsp = 16'hC3A5 ^ 16'(i);
      w   = 16'h5AF0 + 16'(i);
      msk = 16'hFFFF >> (4'hF - sz);
      send(w);
      get_rx(d);
      check("rx word", d, rsp & msk);
      wait_for(2);
      check("peer capture", cap & msk, w & msk);
    end
    // back-to-back words: phase 0 pulses select, phase 1 holds it
    for (int h = 0; h < 2; h++)
    begin
      setup(1'b1, 1'b0, 1'b0, h[0], 4'h7);
      rises = 0;
      send(16'h0096);
      send(16'h0069);
      get_rx(d);
      get_rx(d);
      check("burst rx", d, rsp & 16'h00FF);
      wait_for(2);
      check("select rises", 16'(rises), h ? 16'h0001 : 16'h0002);
      check("burst capture", cap & 16'h00FF, 16'h0069);
    end
    // two control words back to back, 12-bit replies
    setup(1'b1, 1'b1, 1'b0, 1'b0, 4'hB);
    rsp = 16'h0ABC;
    send(16'h00D2);
    send(16'h005B);
    get_rx(d);
    check("reply", d, 16'h0ABC);
    get_rx(d);
    check("last reply", d, 16'h0ABC);
    wait_for(2);
    check("control byte", cap & 16'h00FF, 16'h005B);
    // slave frame on the link clock, 8 bits each way
    setup(1'b0, 1'b0, 1'b0, 1'b0, 4'h7);
    send(16'h00B4);
    repeat (4) @(negedge clk);
    got  = '0;
    fs_s = 1'b0;
    #48;
    for (int b = 7; b >= 0; b--)
    begin
      rx_s = w[b] ^ 1'b1;
      #16 sck_s = 1'b1;
      got = {got[14:0], mosi};
      #16 sck_s = 1'b0;
    end
    #40 fs_s = 1'b1;
    rx_s = ~rx_s;
    get_rx(d);
    check("slave rx", d, ~w & 16'h00FF);
    check("slave tx", got & 16'h00FF, 16'h00B4);
    finish_test();
  end
endmodule
